/* src/iscc_defs.vh */
/*
 * Constants for the interrupt summary and serial output control register block.
 * Assumes an AHB-Lite slave with 32-bit data and one register per aligned word.
 */
`ifndef ISCC_DEFS_VH
`define ISCC_DEFS_VH

// Register indices, byte address is four times the index
`define ISCC_IDX_FORWARDING_STATUS      8'h22
`define ISCC_IDX_INT_CTL      8'h23
`define ISCC_IDX_INT_STS      8'h24
`define ISCC_IDX_RSVD_LO      8'h25
`define ISCC_IDX_RSVD_HI      8'h32
`define ISCC_IDX_OUT_CTL      8'h33
`define ISCC_IDX_TX_SRC       8'h37
`define ISCC_IDX_RX_STS_ONE   8'h4d
`define ISCC_IDX_RX_STS_TWO   8'h4e
`define ISCC_IDX_RX_SIDE_STS  8'h7a
`define ISCC_IDX_EVT_STS      8'hf0
`define ISCC_IDX_EVT_MASK     8'hf1
`define ISCC_IDX_RATE         8'hf2
`define ISCC_IDX_DUP          8'hf3

// Field positions
`define ISCC_BIT_GLOBAL       7
`define ISCC_BIT_TX           4
`define ISCC_BIT_RX           0
`define ISCC_BIT_CAL          6
`define ISCC_BIT_LANE_HI      5
`define ISCC_BIT_LANE_LO      4
`define ISCC_BIT_LP_HI        3
`define ISCC_BIT_LP_LO        2
`define ISCC_BIT_CONT         1
`define ISCC_BIT_EN           0

// Writable bit masks and reset values
`define ISCC_INT_CTL_WMASK    8'h91
`define ISCC_OUT_CTL_WMASK    8'h7f
`define ISCC_RST_8            8'h00
`define ISCC_RATE_RST         2'h2
`define ISCC_RATE_TOP         2'h0
`define ISCC_LANES_MAX        3'h4

// Lowpower force encodings
`define ISCC_LP_NORMAL        2'h0
`define ISCC_LP_DATA          2'h1
`define ISCC_LP_RSVD          2'h2
`define ISCC_LP_ALL           2'h3

// Event status bits
`define ISCC_EVT_TX           0
`define ISCC_EVT_RX           1
`define ISCC_EVT_IRQ          2
`define ISCC_EVT_W            3

// AHB codes
`define ISCC_HTRANS_NONSEQ    2'h2
`define ISCC_HTRANS_SEQ       2'h3
`define ISCC_HSIZE_WORD       3'h2
`define ISCC_ADDR_LSB         2
`define ISCC_ADDR_MSB         9

`endif

/* src/iscc_regs.v */
/*
 * Interrupt summary and serial output control register block, AHB-Lite slave.
 * Assumes single clock hclk, async active-low hresetn, events as one-cycle pulses.
 */
`include "iscc_defs.vh"

module iscc_regs
(
   input  wire        hclk,
   input  wire        hresetn,
   input  wire        hsel,
   input  wire [31:0] haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire [31:0] hwdata,
   input  wire        hready,
   output reg  [31:0] hrdata,
   output reg         hreadyout,
   output reg         hresp,
   input  wire        tx_port_irq_event,
   input  wire        rx_port_irq_event,
   input  wire        first_packet_seen,
   output reg         irq_out,
   output reg         irq_level,
   output reg         tx_output_enable,
   output reg  [2:0]  active_lane_count,
   output reg         lp00_force_data,
   output reg         lp00_force_clock,
   output reg         continuous_clock_on,
   output reg         skew_cal_initial,
   output reg  [1:0]  tx_rate_select,
   output reg         output_duplicate,
   output reg         dup_lane_violation,
   output reg         cal_rate_advice
);

   reg  [7:0]  int_ctl_reg;
   reg  [7:0]  out_ctl_reg;
   reg         tx_port_irq_flag_reg;
   reg         rx_port_irq_flag_reg;
   reg  [2:0]  rx_read_seen_reg;
   reg  [`ISCC_EVT_W-1:0] evt_sts_reg;
   reg  [`ISCC_EVT_W-1:0] evt_mask_reg;
   reg  [1:0]  rate_reg;
   reg         dup_reg;
   reg         cont_armed_reg;
   reg         wr_pend_reg;
   reg  [7:0]  wr_idx_reg;

   wire [7:0]  idx = haddr[`ISCC_ADDR_MSB:`ISCC_ADDR_LSB];
   wire        active = hsel && hready && (htrans == `ISCC_HTRANS_NONSEQ ||
                                           htrans == `ISCC_HTRANS_SEQ);
   wire        rd = active && !hwrite;
   wire        wr_now = wr_pend_reg;

   wire        rd_tx_src = rd && idx == `ISCC_IDX_TX_SRC;
   wire        rd_one    = rd && idx == `ISCC_IDX_RX_STS_ONE;
   wire        rd_two    = rd && idx == `ISCC_IDX_RX_STS_TWO;
   wire        rd_side   = rd && idx == `ISCC_IDX_RX_SIDE_STS;
   wire [2:0]  rx_seen_next = rx_read_seen_reg | {rd_side, rd_two, rd_one};

   wire        tx_src_on = tx_port_irq_flag_reg & int_ctl_reg[`ISCC_BIT_TX];
   wire        rx_src_on = rx_port_irq_flag_reg & int_ctl_reg[`ISCC_BIT_RX];
   wire        summary   = tx_src_on | rx_src_on;
   wire        irq_next  = summary & int_ctl_reg[`ISCC_BIT_GLOBAL];

   wire [7:0]  int_sts_val = {summary, 2'h0, tx_port_irq_flag_reg, 3'h0,
                              rx_port_irq_flag_reg};
   wire [1:0]  lane_field = out_ctl_reg[`ISCC_BIT_LANE_HI:`ISCC_BIT_LANE_LO];
   wire [1:0]  lp_field   = out_ctl_reg[`ISCC_BIT_LP_HI:`ISCC_BIT_LP_LO];

   reg  [31:0] rdata_next;

   always @*
   begin
      rdata_next = 32'h0;
      case (idx)
         `ISCC_IDX_INT_CTL:  rdata_next = {24'h0, int_ctl_reg};
         `ISCC_IDX_INT_STS:  rdata_next = {24'h0, int_sts_val};
         `ISCC_IDX_OUT_CTL:  rdata_next = {24'h0, out_ctl_reg};
         `ISCC_IDX_EVT_STS:  rdata_next = {29'h0, evt_sts_reg};
         `ISCC_IDX_EVT_MASK: rdata_next = {29'h0, evt_mask_reg};
         `ISCC_IDX_RATE:     rdata_next = {30'h0, rate_reg};
         `ISCC_IDX_DUP:      rdata_next = {31'h0, dup_reg};
         default:            rdata_next = 32'h0;
      endcase
   end

   // Bus phases, zero wait, always OKAY
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
      else
      begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
   end

   // Write address held over into the data phase
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_pend_reg <= 1'b0;
         wr_idx_reg  <= `ISCC_RST_8;
      end
      else
      begin
         wr_pend_reg <= active && hwrite;
         wr_idx_reg  <= idx;
      end
   end

   // Read data launched at the address phase edge
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         hrdata <= 32'h0;
      else if (rd)
         hrdata <= rdata_next;
   end

   // Write strobes in the data phase
   wire        wr_int_ctl  = wr_now && wr_idx_reg == `ISCC_IDX_INT_CTL;
   wire        wr_out_ctl  = wr_now && wr_idx_reg == `ISCC_IDX_OUT_CTL;
   wire        wr_evt_mask = wr_now && wr_idx_reg == `ISCC_IDX_EVT_MASK;
   wire        wr_rate     = wr_now && wr_idx_reg == `ISCC_IDX_RATE;
   wire        wr_dup      = wr_now && wr_idx_reg == `ISCC_IDX_DUP;

   // Interrupt control, enable bits only
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         int_ctl_reg <= `ISCC_RST_8;
      else if (wr_int_ctl)
         int_ctl_reg <= hwdata[7:0] & `ISCC_INT_CTL_WMASK;
   end

   // Output control, bit 7 stays zero
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         out_ctl_reg <= `ISCC_RST_8;
      else if (wr_out_ctl)
         out_ctl_reg <= hwdata[7:0] & `ISCC_OUT_CTL_WMASK;
   end

   // Event mask
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         evt_mask_reg <= {`ISCC_EVT_W{1'b0}};
      else if (wr_evt_mask)
         evt_mask_reg <= hwdata[`ISCC_EVT_W-1:0];
   end

   // Transmitter rate code
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         rate_reg <= `ISCC_RATE_RST;
      else if (wr_rate)
         rate_reg <= hwdata[1:0];
   end

   // Duplication mode
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         dup_reg <= 1'b0;
      else if (wr_dup)
         dup_reg <= hwdata[0];
   end

   // Transmit source flag, set wins over read clear
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         tx_port_irq_flag_reg <= 1'b0;
      else if (tx_port_irq_event)
         tx_port_irq_flag_reg <= 1'b1;
      else if (rd_tx_src)
         tx_port_irq_flag_reg <= 1'b0;
   end

   // Receive source flag, cleared once all three reads are seen
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         rx_port_irq_flag_reg <= 1'b0;
      else if (rx_port_irq_event)
         rx_port_irq_flag_reg <= 1'b1;
      else if (rx_port_irq_flag_reg && &rx_seen_next)
         rx_port_irq_flag_reg <= 1'b0;
   end

   // Read tracking restarts on a new receive event
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         rx_read_seen_reg <= 3'h0;
      else if (rx_port_irq_event || (rx_port_irq_flag_reg && &rx_seen_next))
         rx_read_seen_reg <= 3'h0;
      else if (rx_port_irq_flag_reg)
         rx_read_seen_reg <= rx_seen_next;
   end

   // Event status, write one to clear, set wins
   wire [`ISCC_EVT_W-1:0] evt_in = {irq_next & ~irq_out, rx_port_irq_event,
                                    tx_port_irq_event};
   wire [`ISCC_EVT_W-1:0] evt_clr = (wr_now && wr_idx_reg == `ISCC_IDX_EVT_STS) ?
                                    hwdata[`ISCC_EVT_W-1:0] : {`ISCC_EVT_W{1'b0}};

   genvar g;
   generate
      for (g = 0; g < `ISCC_EVT_W; g = g + 1)
      begin : g_evt
         always @(posedge hclk or negedge hresetn)
         begin
            if (!hresetn)
               evt_sts_reg[g] <= 1'b0;
            else if (evt_in[g])
               evt_sts_reg[g] <= 1'b1;
            else if (evt_clr[g])
               evt_sts_reg[g] <= 1'b0;
         end
      end
   endgenerate

   // Interrupt output follows global enable and summary
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         irq_out <= 1'b0;
      else
         irq_out <= irq_next;
   end

   // Level interrupt from masked event status
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         irq_level <= 1'b0;
      else
         irq_level <= |(evt_sts_reg & evt_mask_reg);
   end

   // Output control decode
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         tx_output_enable <= 1'b0;
      else
         tx_output_enable <= out_ctl_reg[`ISCC_BIT_EN];
   end

   // Lane count, four down to one
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         active_lane_count <= `ISCC_LANES_MAX;
      else
         active_lane_count <= `ISCC_LANES_MAX - {1'b0, lane_field};
   end

   // Lowpower force, reserved code acts as normal
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         lp00_force_data <= 1'b0;
      else
         lp00_force_data <= lp_field == `ISCC_LP_DATA ||
                            lp_field == `ISCC_LP_ALL;
   end

   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         lp00_force_clock <= 1'b0;
      else
         lp00_force_clock <= lp_field == `ISCC_LP_ALL;
   end

   // Continuous clock armed by the first packet
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         cont_armed_reg <= 1'b0;
      else if (!out_ctl_reg[`ISCC_BIT_CONT] || !out_ctl_reg[`ISCC_BIT_EN])
         cont_armed_reg <= 1'b0;
      else if (first_packet_seen)
         cont_armed_reg <= 1'b1;
   end

   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         continuous_clock_on <= 1'b0;
      else
         continuous_clock_on <= cont_armed_reg && out_ctl_reg[`ISCC_BIT_CONT] &&
                                out_ctl_reg[`ISCC_BIT_EN];
   end

   // Initial skew calibration request
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         skew_cal_initial <= 1'b0;
      else
         skew_cal_initial <= out_ctl_reg[`ISCC_BIT_CAL];
   end

   // Rate and duplication
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         tx_rate_select <= `ISCC_RATE_RST;
      else
         tx_rate_select <= rate_reg;
   end

   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         output_duplicate <= 1'b0;
      else
         output_duplicate <= dup_reg;
   end

   // Duplication with three or four lanes
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         dup_lane_violation <= 1'b0;
      else
         dup_lane_violation <= dup_reg && !lane_field[1];
   end

   // Top rate without calibration
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         cal_rate_advice <= 1'b0;
      else
         cal_rate_advice <= rate_reg == `ISCC_RATE_TOP &&
                            !out_ctl_reg[`ISCC_BIT_CAL];
   end

endmodule // iscc_regs

/* tb/iscc_regs_properties.sv */
/* Port checker for iscc_regs.
   Assumes a zero-wait AHB-Lite slave; bound onto every iscc_regs. */
module iscc_regs_chk
(
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [31:0] hwdata,
   input wire logic        hready,
   input wire logic        tx_port_irq_event,
   input wire logic        rx_port_irq_event,
   input wire logic        irq_out,
   input wire logic        tx_output_enable,
   input wire logic [2:0]  active_lane_count,
   input wire logic        lp00_force_data,
   input wire logic        lp00_force_clock,
   input wire logic        continuous_clock_on,
   input wire logic        skew_cal_initial
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   logic wic, woc, gen, itx, irx;
   wire  wr = hsel && hready && htrans[1] && hwrite;
   // Shadow of the interrupt enables
   always @(posedge hclk or negedge hresetn)
      if (!hresetn)
         {wic, woc, gen, itx, irx} <= 5'h0;
      else
      begin
         wic <= wr && haddr[9:2] == 8'h23;
         woc <= wr && haddr[9:2] == 8'h33;
         if (wic)
            {gen, itx, irx} <= {hwdata[7], hwdata[4], hwdata[0]};
      end
   AST_OUT_EN: assert property (woc |-> ##2 tx_output_enable == $past(hwdata[0], 2))
      else $error("output enable mismatch");
   AST_CAL: assert property (woc |-> ##2 skew_cal_initial == $past(hwdata[6], 2))
      else $error("calibration mismatch");
   AST_LANES: assert property (woc |-> ##2
      active_lane_count == 3'h4 - {1'b0, $past(hwdata[5:4], 2)})
      else $error("lane count mismatch");
   AST_LP: assert property (woc |-> ##2 {lp00_force_clock, lp00_force_data} ==
      {&$past(hwdata[3:2], 2), $past(hwdata[2], 2)})
      else $error("lowpower force mismatch");
   AST_CONT: assert property (continuous_clock_on |-> tx_output_enable)
      else $error("continuous clock while off");
   AST_GLOBAL: assert property ((!gen)[*3] |-> !irq_out)
      else $error("interrupt without global enable");
   AST_TX_IRQ: assert property (gen && itx && tx_port_irq_event |-> ##2 irq_out)
      else $error("transmit interrupt missing");
   AST_RX_IRQ: assert property (gen && irx && rx_port_irq_event |-> ##2 irq_out)
      else $error("receive interrupt missing");
   AST_MASK: assert property ((!itx && !irx)[*3] |-> !irq_out)
      else $error("interrupt with no source enabled");
endmodule // iscc_regs_chk

bind iscc_regs iscc_regs_chk u_chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
   .hwdata, .hready, .tx_port_irq_event, .rx_port_irq_event, .irq_out, .tx_output_enable,
   .active_lane_count, .lp00_force_data, .lp00_force_clock, .continuous_clock_on,
   .skew_cal_initial);

/* tb/iscc_host_model.sv */
/* Host controller model counting interrupt requests.
   Assumes irq_out is a level held high while service is wanted. */
module iscc_host_model
(
   input  wire logic hclk,
   input  wire logic hresetn,
   input  wire logic irq_out,
   output int        irq_count
);
   timeunit 1ns;
   timeprecision 1ns;
   logic irq_q;
   always @(posedge hclk or negedge hresetn)
      if (!hresetn)
         {irq_q, irq_count} <= '0;
      else
      begin
         irq_q <= irq_out;
         irq_count <= irq_count + (irq_out && !irq_q);
      end
endmodule // iscc_host_model

/* tb/tb_top.sv */
/* Self-checking bench for iscc_regs.
   Assumes one clock, zero-wait AHB-Lite, host model on irq_out. */
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic        hclk, hresetn, hsel, hwrite, tx_ev, rx_ev, fps;
   logic        hreadyout, hresp, irq_out, irq_level, oe, lpd, lpc, cont, cal, dup, viol, adv;
   logic [31:0] haddr, hwdata, hrdata, rd, w;
   logic [1:0]  htrans, rate;
   logic [2:0]  hsize, lanes;
   int          fail_count, n_compared, irq_count, i;
   wire         hready = hreadyout;
   iscc_regs u_iscc_regs (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
      .hready, .hrdata, .hreadyout, .hresp, .tx_port_irq_event(tx_ev), .rx_port_irq_event(rx_ev),
      .first_packet_seen(fps), .irq_out, .irq_level, .tx_output_enable(oe),
      .active_lane_count(lanes), .lp00_force_data(lpd), .lp00_force_clock(lpc),
      .continuous_clock_on(cont), .skew_cal_initial(cal), .tx_rate_select(rate),
      .output_duplicate(dup), .dup_lane_violation(viol), .cal_rate_advice(adv));
   iscc_host_model u_iscc_host_model (.hclk, .hresetn, .irq_out, .irq_count);
   initial
   begin
      hclk = 1'b0;
      forever #25 hclk = ~hclk;
   end
   task print_verdict;
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e)
      begin
         fail_count++;
         $display("wrong value %s exp %h got %h", nm, e, g);
      end
   endtask
   task hwait;
      int n;
      n = 0;
      do
      begin
         @(posedge hclk);
         n++;
      end
      while (hready !== 1'b1 && n < 20);
      if (hready !== 1'b1)
      begin
         fail_count++;
         print_verdict;
      end
   endtask
   task ahb(input logic wr, input logic [7:0] ix, input logic [31:0] wd);
      {hsel, htrans, hwrite, haddr} <= {1'b1, 2'h2, wr, 22'h0, ix, 2'h0};
      hwait;
      {htrans, hwdata} <= {2'h0, wd};
      hwait;
      rd = hrdata;
   endtask
   task rdchk(input string nm, input logic [7:0] ix, input logic [31:0] e);
      ahb(1'b0, ix, 32'h0);
      chk(nm, e, rd);
   endtask
   task ev(input logic t, input logic r);
      {tx_ev, rx_ev} <= {t, r};
      @(posedge hclk);
      {tx_ev, rx_ev} <= 2'h0;
      repeat (3) @(posedge hclk);
   endtask
   function logic [2:0] lanes_of(input logic [1:0] f);
      return 3'h4 - {1'b0, f};
   endfunction
   initial
   begin
      {hresetn, hsel, hwrite, tx_ev, rx_ev, fps, htrans, haddr, hwdata} = '0;
      hsize = 3'h2;
      {fail_count, n_compared} = '0;
      void'($urandom(46672));
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rdchk("int_ctl", 8'h23, 32'h0);
      rdchk("int_sts", 8'h24, 32'h0);
      rdchk("out_ctl", 8'h33, 32'h0);
      chk("lane count", 32'h4, lanes);
      chk("rate reset", 32'h4, {rate, dup});
      chk("bus answer", 32'h2, {hreadyout, hresp});
      $display("test reset done");
      for (i = 8'h22; i <= 8'h32; i++)
         if (i != 8'h23 && i != 8'h24)
         begin
            ahb(1'b1, i[7:0], $urandom);
            rdchk("reserved", i[7:0], 32'h0);
         end
      $display("test reserved done");
      for (i = 0; i < 16; i++)
      begin
         w = $urandom;
         w[5:2] = i[3:0];
         ahb(1'b1, 8'h33, w);
         rdchk("out_ctl", 8'h33, w & 32'h7f);
         chk("fields", {lanes_of(w[5:4]), w[3:2] == 2'h3, w[2], w[6], w[0]}, {lanes, lpc, lpd, cal, oe});
      end
      ahb(1'b1, 8'h33, 32'h0);
      ahb(1'b1, 8'h33, 32'h3);
      repeat (3) @(posedge hclk);
      chk("cont early", 32'h0, cont);
      fps <= 1'b1;
      @(posedge hclk);
      fps <= 1'b0;
      repeat (3) @(posedge hclk);
      chk("cont", 32'h1, cont);
      ahb(1'b1, 8'h33, 32'h2);
      repeat (2) @(posedge hclk);
      chk("cont off", 32'h0, {cont, oe});
      $display("test output control done");
      ahb(1'b1, 8'h23, 32'hff);
      rdchk("int_ctl", 8'h23, 32'h91);
      ev(1'b1, 1'b0);
      rdchk("sts tx", 8'h24, 32'h90);
      chk("irq on", 32'h1, irq_out);
      rdchk("tx source", 8'h37, 32'h0);
      rdchk("sts clr", 8'h24, 32'h0);
      ev(1'b0, 1'b1);
      ahb(1'b1, 8'h23, 32'h1);
      rdchk("sts rx", 8'h24, 32'h81);
      chk("irq off", 32'h0, irq_out);
      rdchk("rx one", 8'h4d, 32'h0);
      rdchk("rx two", 8'h4e, 32'h0);
      rdchk("sts part", 8'h24, 32'h81);
      rdchk("rx side", 8'h7a, 32'h0);
      rdchk("sts rx clr", 8'h24, 32'h0);
      ahb(1'b1, 8'h23, 32'h0);
      ev(1'b1, 1'b0);
      rdchk("sts masked", 8'h24, 32'h10);
      chk("host count", 32'h2, irq_count);
      $display("test summary done");
      ahb(1'b1, 8'hf0, 32'h7);
      ahb(1'b1, 8'hf1, 32'h1);
      ev(1'b0, 1'b1);
      chk("level masked", 32'h0, irq_level);
      ev(1'b1, 1'b0);
      chk("level", 32'h1, irq_level);
      ahb(1'b1, 8'hf0, 32'h1);
      rdchk("evt sts", 8'hf0, 32'h2);
      chk("level clr", 32'h0, irq_level);
      $display("test events done");
      ahb(1'b1, 8'hf2, 32'h0);
      ahb(1'b1, 8'h33, 32'h61);
      ahb(1'b1, 8'hf3, 32'h1);
      repeat (3) @(posedge hclk);
      chk("rate dup", 32'h4, {rate, dup, adv, viol});
      ahb(1'b1, 8'h33, 32'h1);
      repeat (3) @(posedge hclk);
      chk("advice", 32'h3, {adv, viol});
      $display("test rate done");
      print_verdict;
   end
endmodule // tb_top
